// file: pcmc_defs.vh
`ifndef PCMC_DEFS_VH
`define PCMC_DEFS_VH
// Contract
// - The oscillation stabilization wait is inserted after reset or standby release even with an external clock.
// - PLL mode supplies the CPU and peripheral clock at four times the oscillator rate; clock-through passes it unchanged.
// - The PLL control register is eight bits, byte or bit accessible, and resets to 01H; the code keeps only bits 3:0 and writes them through byte lane 0.
// - After reset the PLL runs (run bit 1) while the source select is 0, so clock-through is in use.

// ********************************
// Register map (byte addresses)
// ********************************
`define PCMC_ADDR_PLL_CONTROL 12'h000
`define PCMC_ADDR_PROC_CLOCK 12'h004
`define PCMC_ADDR_STATUS 12'h008

// ********************************
// Fields and reset values
// ********************************
`define PCMC_BIT_PLL_RUN 0
`define PCMC_BIT_SRC_SEL 1
`define PCMC_PLL_CONTROL_RESET 8'h01
`define PCMC_PLL_CONTROL_MASK 8'h0F
`define PCMC_BIT_FB_CUTOFF 0
`define PCMC_ST_LOCKED 0
`define PCMC_ST_PLL_ACTIVE 1
`define PCMC_ST_STABLE 2
`define PCMC_ST_EXT_PAIR_OK 3
`define PCMC_ST_SWITCHING 4

// ********************************
// Timing
// ********************************
`define PCMC_CLK_MHZ 125
`define PCMC_LOCK_TIME_US 200
`define PCMC_LOCK_CYCLES (`PCMC_LOCK_TIME_US * `PCMC_CLK_MHZ)
`define PCMC_OSC_STAB_CYCLES 16384
`define PCMC_SWITCH_GAP_CYCLES 3'h2
`define PCMC_RATIO_PLL 3'h4
`define PCMC_RATIO_THROUGH 3'h1

`endif

// file: pcmc_top.v
`timescale 1ns/100ps
`include "pcmc_defs.vh"

module pcmc_top #(
    parameter LOCK_CYCLES = `PCMC_LOCK_CYCLES,
    parameter OSC_STAB_CYCLES = `PCMC_OSC_STAB_CYCLES
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire osc_in_pin,
    input wire osc_out_pin,
    input wire standby,
    output reg pll_enable,
    output reg gate_through_en,
    output reg gate_pll_en,
    output reg [2:0] clock_ratio,
    output reg feedback_resistor_cutoff,
    output reg osc_stable
);

    // ********************************
    // Register state
    // ********************************
    reg [7:0] pll_control;
    reg [7:0] processor_clock_control;
    wire pll_run = pll_control[`PCMC_BIT_PLL_RUN];
    wire clock_source_select = pll_control[`PCMC_BIT_SRC_SEL];

    // ********************************
    // Pin synchronisers
    // ********************************
    reg osc_in_meta, osc_in_sync, osc_out_meta, osc_out_sync;
    reg ext_pair_ok;

    always @(posedge clk_sys) begin
        if (rst) begin
            osc_in_meta <= 1'b0;
            osc_in_sync <= 1'b0;
            osc_out_meta <= 1'b0;
            osc_out_sync <= 1'b0;
            ext_pair_ok <= 1'b0;
        end else begin
            osc_in_meta <= osc_in_pin;
            osc_in_sync <= osc_in_meta;
            osc_out_meta <= osc_out_pin;
            osc_out_sync <= osc_out_meta;
            // Sampled view only; a true check needs the analog cell
            ext_pair_ok <= osc_in_sync ^ osc_out_sync;
        end
    end

    // ********************************
    // Oscillation stabilization wait
    // ********************************
    reg [15:0] stab_count;
    reg standby_q;
    wire standby_release = standby_q & ~standby;

    always @(posedge clk_sys) begin
        if (rst) begin
            stab_count <= 16'h0000;
            osc_stable <= 1'b0;
            standby_q <= 1'b0;
        end else begin
            standby_q <= standby;
            // No bypass for external clocks: the wait always runs
            if (standby_release) begin
                stab_count <= 16'h0000;
                osc_stable <= 1'b0;
            end else if (!osc_stable) begin
                if (stab_count == OSC_STAB_CYCLES[15:0] - 16'h0001) begin
                    osc_stable <= 1'b1;
                end else begin
                    stab_count <= stab_count + 16'h0001;
                end
            end
        end
    end

    // ********************************
    // PLL lock timer
    // ********************************
    reg [15:0] lock_count;
    reg pll_locked;

    always @(posedge clk_sys) begin
        if (rst) begin
            lock_count <= 16'h0000;
            pll_locked <= 1'b0;
            pll_enable <= 1'b0;
        end else begin
            pll_enable <= pll_run;
            if (!pll_run) begin
                lock_count <= 16'h0000;
                pll_locked <= 1'b0;
            end else if (!pll_locked) begin
                if (lock_count == LOCK_CYCLES[15:0] - 16'h0001) begin
                    pll_locked <= 1'b1;
                end else begin
                    lock_count <= lock_count + 16'h0001;
                end
            end
        end
    end

    // ********************************
    // Glitch-free source switch
    // ********************************
    // Both gates close for a gap before the new one opens, so no
    // shortened pulse reaches the system clock at the change.
    localparam SW_RUN = 2'b00;
    localparam SW_GAP = 2'b01;
    localparam SW_OPEN = 2'b10;

    reg [1:0] sw_state;
    reg [2:0] gap_count;
    reg pll_active;
    // Kept shut in the release cycle too: osc_stable only drops one edge later
    wire clocks_allowed = osc_stable & ~standby & ~standby_q;

    always @(posedge clk_sys) begin
        if (rst) begin
            sw_state <= SW_RUN;
            gap_count <= 3'h0;
            pll_active <= 1'b0;
            gate_through_en <= 1'b0;
            gate_pll_en <= 1'b0;
            clock_ratio <= `PCMC_RATIO_THROUGH;
        end else begin
            case (sw_state)
                SW_RUN: begin
                    gate_through_en <= clocks_allowed & ~pll_active;
                    gate_pll_en <= clocks_allowed & pll_active;
                    if (clock_source_select != pll_active) begin
                        gate_through_en <= 1'b0;
                        gate_pll_en <= 1'b0;
                        gap_count <= 3'h0;
                        sw_state <= SW_GAP;
                    end
                end
                SW_GAP: begin
                    if (gap_count == `PCMC_SWITCH_GAP_CYCLES - 3'h1) begin
                        pll_active <= clock_source_select;
                        sw_state <= SW_OPEN;
                    end else begin
                        gap_count <= gap_count + 3'h1;
                    end
                end
                SW_OPEN: begin
                    // Multiplied clock is four times the oscillator rate
                    clock_ratio <= pll_active ? `PCMC_RATIO_PLL : `PCMC_RATIO_THROUGH;
                    gate_through_en <= clocks_allowed & ~pll_active;
                    gate_pll_en <= clocks_allowed & pll_active;
                    sw_state <= SW_RUN;
                end
                default: begin
                    sw_state <= SW_RUN;
                end
            endcase
        end
    end

    // ********************************
    // APB slave, no wait states
    // ********************************
    function [1:0] decode;
        input [11:0] addr;
        begin
            if (addr == `PCMC_ADDR_PLL_CONTROL) begin
                decode = 2'h1;
            end else if (addr == `PCMC_ADDR_PROC_CLOCK) begin
                decode = 2'h2;
            end else if (addr == `PCMC_ADDR_STATUS) begin
                decode = 2'h3;
            end else begin
                decode = 2'h0;
            end
        end
    endfunction

    wire [1:0] sel = decode(paddr);
    wire setup = psel & ~penable;
    wire finish = psel & penable & pready;
    wire wr_lane0 = finish & pwrite & pstrb[0];
    wire [7:0] status = {3'h0, (sw_state != SW_RUN), ext_pair_ok, osc_stable,
                         pll_active, pll_locked};
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = 8'h00;
        if (sel == 2'h1) begin
            next_rdata = pll_control & `PCMC_PLL_CONTROL_MASK;
        end else if (sel == 2'h2) begin
            next_rdata = processor_clock_control;
        end else if (sel == 2'h3) begin
            next_rdata = status;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            pll_control <= `PCMC_PLL_CONTROL_RESET;
            processor_clock_control <= 8'h00;
            feedback_resistor_cutoff <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= {24'h00_0000, next_rdata};
                pslverr <= (sel == 2'h0) | (pwrite & (sel == 2'h3));
            end else begin
                pslverr <= 1'b0;
            end
            // Byte lane 0 carries the whole 8-bit register
            if (wr_lane0 && sel == 2'h1) begin
                pll_control <= pwdata[7:0] & `PCMC_PLL_CONTROL_MASK;
            end
            if (wr_lane0 && sel == 2'h2) begin
                processor_clock_control <= pwdata[7:0];
            end
            feedback_resistor_cutoff <= processor_clock_control[`PCMC_BIT_FB_CUTOFF];
        end
    end

endmodule

// file: pcmc_osc_src.sv
`timescale 1ns/100ps
module pcmc_osc_src (
    input wire clk_sys,
    output logic osc_in_pin,
    output logic osc_out_pin
);
    logic [3:0] div = 4'h0;
    // Slow rate keeps the device's 2-FF pin sampling meaningful
    initial begin
        osc_in_pin = 1'h0;
        osc_out_pin = 1'h1;
    end
    always @(posedge clk_sys) begin
        div <= div + 4'h1;
        if (div == 4'hf) begin
            osc_in_pin <= ~osc_in_pin;
            osc_out_pin <= osc_in_pin;
        end
    end
endmodule

// file: pcmc_props.sv
`timescale 1ns/100ps
module pcmc_props (
    input wire clk_sys,
    input wire rst,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire pll_enable,
    input wire gate_through_en,
    input wire gate_pll_en,
    input wire [2:0] clock_ratio,
    input wire osc_stable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_excl;
        !(gate_through_en && gate_pll_en);
    endproperty
    a_excl: assert property (p_excl) else $error("both gates open");
    property p_gap;
        $fell(gate_through_en) |-> !gate_pll_en [*2];
    endproperty
    a_gap: assert property (p_gap) else $error("no gap at switch");
    property p_gap_back;
        $fell(gate_pll_en) |-> !gate_through_en [*2];
    endproperty
    a_gap_back: assert property (p_gap_back) else $error("no gap at switch back");
    property p_pll;
        gate_pll_en |-> clock_ratio == 3'h4;
    endproperty
    a_pll: assert property (p_pll) else $error("pll ratio wrong");
    property p_thru;
        gate_through_en |-> clock_ratio == 3'h1;
    endproperty
    a_thru: assert property (p_thru) else $error("through ratio wrong");
    property p_stab;
        (gate_through_en || gate_pll_en) |-> osc_stable;
    endproperty
    a_stab: assert property (p_stab) else $error("gate open before stable");
    property p_rst;
        $fell(rst) |-> ##1 pll_enable && clock_ratio == 3'h1;
    endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_rd;
        pready && !pwrite && paddr == 12'h000 |-> prdata[31:4] == 28'h000_0000 && !pslverr;
    endproperty
    a_rd: assert property (p_rd) else $error("control read wrong");
endmodule
bind pcmc_top pcmc_props i_pcmc_props (.clk_sys, .rst, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .pll_enable, .gate_through_en, .gate_pll_en, .clock_ratio, .osc_stable);

// file: pcmc_top_tb.sv
`timescale 1ns/100ps
module pcmc_top_tb;
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic x;} pcmc_row_t;
    logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic standby = 1'h0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [3:0] pstrb = 4'h1;
    wire [31:0] prdata;
    wire [2:0] clock_ratio;
    wire pready, pslverr, osc_in_pin, osc_out_pin, pll_enable, gate_through_en, gate_pll_en;
    wire feedback_resistor_cutoff, osc_stable;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    pcmc_row_t rows [7] = '{'{0, 12'h000, 8'h00, 8'h01, 0}, '{1, 12'h000, 8'hfd, 8'h00, 0},
        '{0, 12'h000, 8'h00, 8'h0d, 0}, '{1, 12'h004, 8'h01, 8'h00, 0},
        '{0, 12'h004, 8'h00, 8'h01, 0}, '{0, 12'h00c, 8'h00, 8'h00, 1},
        '{1, 12'h008, 8'h00, 8'h00, 1}};
    // Short counts keep the run brief
    pcmc_top #(.LOCK_CYCLES(20), .OSC_STAB_CYCLES(16)) i_pcmc_top (.clk_sys, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .osc_in_pin,
        .osc_out_pin, .standby, .pll_enable, .gate_through_en, .gate_pll_en, .clock_ratio,
        .feedback_resistor_cutoff, .osc_stable);
    pcmc_osc_src i_pcmc_osc_src (.clk_sys, .osc_in_pin, .osc_out_pin);
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wait_stable;
        repeat (100) if (osc_stable !== 1'h1) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask
    task results;
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Cycle ceiling well above the hundred or so cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("prdata", 32'(rows[i].e), rd);
            chk("pslverr", 32'(rows[i].x), 32'(er));
        end
        $display("register table done");
        wait_stable();
        chk("gate_through_en", 1, gate_through_en);
        chk("clock_ratio", 1, clock_ratio);
        chk("fb_cutoff", 1, feedback_resistor_cutoff);
        apb(0, 12'h008, 8'h00);
        chk("status", 32'h0000_000d, rd);
        apb(1, 12'h000, 8'h03);
        repeat (8) @(posedge clk_sys);
        chk("gate_pll_en", 1, gate_pll_en);
        chk("clock_ratio", 4, clock_ratio);
        apb(1, 12'h000, 8'h01);
        repeat (8) @(posedge clk_sys);
        chk("clock_ratio", 1, clock_ratio);
        apb(1, 12'h000, 8'h00);
        standby <= 1'h1;
        repeat (4) @(posedge clk_sys);
        chk("pll_enable", 0, pll_enable);
        chk("gate_through_en", 0, gate_through_en);
        standby <= 1'h0;
        repeat (2) @(posedge clk_sys);
        chk("osc_stable", 0, osc_stable);
        wait_stable();
        chk("gate_through_en", 1, gate_through_en);
        $display("clock switch done");
        pstrb <= 4'h0;
        apb(1, 12'h004, 8'h00);
        chk("pslverr", 0, 32'(er));
        pstrb <= 4'h1;
        apb(0, 12'h004, 8'h00);
        chk("prdata", 32'h0000_0001, rd);
        chk("fb_cutoff", 1, feedback_resistor_cutoff);
        $display("strobe test done");
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        chk("gate_through_en", 0, gate_through_en);
        @(posedge clk_sys);
        chk("pll_enable", 1, pll_enable);
        chk("clock_ratio", 1, clock_ratio);
        apb(0, 12'h000, 8'h00);
        chk("prdata", 32'h0000_0001, rd);
        $display("second reset done");
        results();
    end
endmodule
